// File: hdl/ptw_pkg.sv
// Package: register map, field layout, reset values and timing for the timer unit
package ptw_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRESC = 8'h04;
  localparam logic [7:0] OFF_T1 = 8'h08;
  localparam logic [7:0] OFF_T2 = 8'h0C;
  localparam logic [7:0] OFF_T3 = 8'h10;
  localparam logic [7:0] OFF_RELOAD = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_WDOG = 8'h1C;
  // Control register bit positions
  localparam int CTRL_PS_RUN = 0;
  localparam int CTRL_T1_RUN = 1;
  localparam int CTRL_T2_RUN = 2;
  localparam int CTRL_T3_RUN = 3;
  localparam int CTRL_T1_EXT = 4;
  localparam int CTRL_T1_FALL = 5;
  localparam int CTRL_T2_SRC = 6;
  localparam int CTRL_T3_SRC = 7;
  localparam int CTRL_PWM_EN = 8;
  localparam int CTRL_PWM_EXP = 9;
  localparam int CTRL_EXT_CLK = 10;
  localparam int CTRL_PORTC = 11;
  localparam int CTRL_W = 12;
  // Watchdog command register bits
  localparam int WD_DISABLE = 0;
  localparam int WD_RESTART = 1;
  localparam int WD_POWEROFF = 2;
  // Reset values
  localparam logic [11:0] CTRL_RST = 12'h800;
  localparam logic [7:0] CNT_RST = 8'hFF;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int PS_DIV_DEF = 4;
  localparam int WDT_W_DEF = 16;
endpackage

// File: hdl/ptw_tick_if.sv
// Interface: one count-source tick and underflow pair per timer
`timescale 1ns/1ps
interface ptw_tick_if;
  logic tick;
  logic run;
  logic uflow;
  modport src (output tick, output run, input uflow);
  modport cnt (input tick, input run, output uflow);
endinterface

// File: hdl/ptw_down_counter.sv
// Module: 8-bit reloading down counter without start-phase alignment
`timescale 1ns/1ps
module ptw_down_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick and status
  ptw_tick_if.cnt tk,
  // Load and reload
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] reload_val,
  output logic [W-1:0] count
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic hit;
  // Count begins at first tick after start; the partial tick period is lost
  assign hit = tk.run && tk.tick;
  assign tk.uflow = hit && (cnt_q == '0);
  // Decrement on tick, reload after zero
  assign cnt_d = load ? load_val :
                 !hit ? cnt_q :
                 (cnt_q == '0) ? reload_val : cnt_q - 1'b1;
  assign count = cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '1;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // ptw_down_counter

// File: hdl/ptw_timer_unit.sv
// Top: prescaler, three timers with PWM, watchdog, APB register slave
// Notes on behaviour
// - Stopping timer 3 at its underflow may glitch PWM; avoid it.
// - Counting starts on the first count-source tick after start.
// - First underflow may come up to one source period early.
// - External count input clocks timer 1 on the selected edge.
// - Watchdog runs from reset release with no software action.
// - Disable followed at once by restart clears the enable flag.
// - Back-up entry clears the watchdog first-stage flag and sets the counter to all ones.
// - Back-up entry is refused while running from external clock.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ptw_timer_unit #(
  parameter int PS_DIV = ptw_pkg::PS_DIV_DEF,
  parameter int WDT_W = ptw_pkg::WDT_W_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic external_count_input,
  output logic pwm_output_pin,
  // Status
  output logic watchdog_reset,
  output logic backup_active
);
  localparam int NT = 3;
  logic [11:0] ctrl_q;
  logic [7:0] ps_q;
  logic [7:0] ps_reload_q;
  logic [7:0] r1_q;
  logic [7:0] r2_q;
  logic [7:0] r3l_q;
  logic [7:0] r3h_q;
  logic [2:0] flag_q;
  logic ext_q;
  logic pwm_q;
  logic pwm_hi_q;
  logic wef_q;
  logic watchdog_first_stage_flag_q;
  logic dis_pend_q;
  logic [WDT_W-1:0] wdt_q;
  logic wdrst_q;
  logic bkup_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [$clog2(PS_DIV)-1:0] div_q;
  logic sys_tick;
  logic ps_tick;
  logic ext_edge;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_ps;
  logic hit_t1;
  logic hit_t2;
  logic hit_t3;
  logic hit_rl;
  logic hit_fl;
  logic hit_wd;
  logic mapped;
  logic [7:0] cnt [NT];
  logic [7:0] rel [NT];
  logic [NT-1:0] ld;
  logic [NT-1:0] uf;
  logic [NT-1:0] src;
  logic [31:0] rdata;
  logic bkup_req;
  ptw_tick_if tki [NT] ();

  // APB decode
  // Writes land on the edge that samples pready high
  assign wr = psel && penable && pwrite && pready_q;
  assign rd = psel && penable && !pwrite && !pready_q;
  assign hit_ctrl = paddr == ptw_pkg::OFF_CTRL;
  assign hit_ps = paddr == ptw_pkg::OFF_PRESC;
  assign hit_t1 = paddr == ptw_pkg::OFF_T1;
  assign hit_t2 = paddr == ptw_pkg::OFF_T2;
  assign hit_t3 = paddr == ptw_pkg::OFF_T3;
  assign hit_rl = paddr == ptw_pkg::OFF_RELOAD;
  assign hit_fl = paddr == ptw_pkg::OFF_FLAGS;
  assign hit_wd = paddr == ptw_pkg::OFF_WDOG;
  assign mapped = hit_ctrl | hit_ps | hit_t1 | hit_t2 | hit_t3 | hit_rl |
                  hit_fl | hit_wd;

  // System divider and prescaler ticks
  assign sys_tick = div_q == '0;
  assign ps_tick = ctrl_q[ptw_pkg::CTRL_PS_RUN] && sys_tick && ps_q == '0;
  // Selected edge of the external count input
  assign ext_edge = ctrl_q[ptw_pkg::CTRL_T1_FALL] ?
                    (ext_q && !external_count_input) :
                    (!ext_q && external_count_input);

  assign src[0] = ctrl_q[ptw_pkg::CTRL_T1_EXT] ? ext_edge : ps_tick;
  assign src[1] = ctrl_q[ptw_pkg::CTRL_T2_SRC] ? uf[0] : ps_tick;
  assign src[2] = ctrl_q[ptw_pkg::CTRL_T3_SRC] ? uf[1] : ps_tick;
  assign ld[0] = wr && hit_t1;
  assign ld[1] = wr && hit_t2;
  assign ld[2] = wr && hit_t3;
  assign rel[0] = r1_q;
  assign rel[1] = r2_q;
  // Timer 3 alternates reloads in PWM mode
  assign rel[2] = (ctrl_q[ptw_pkg::CTRL_PWM_EN] && !pwm_hi_q) ? r3h_q :
                  r3l_q;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      assign tki[gi].tick = src[gi];
      assign tki[gi].run = ctrl_q[ptw_pkg::CTRL_T1_RUN + gi];
      assign uf[gi] = tki[gi].uflow;
      ptw_down_counter #(.W(8)) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .tk(tki[gi]),
        .load(ld[gi]),
        .load_val(pwdata[7:0]),
        .reload_val(rel[gi]),
        .count(cnt[gi])
      );
    end
  endgenerate

  // Back-up entry refused on external clock
  assign bkup_req = wr && hit_wd && pwdata[ptw_pkg::WD_POWEROFF] &&
                    !ctrl_q[ptw_pkg::CTRL_EXT_CLK];

  assign rdata = hit_ctrl ? {20'h0_0000, ctrl_q} :
                 hit_ps ? {16'h0000, ps_reload_q, ps_q} :
                 hit_t1 ? {24'h00_0000, cnt[0]} :
                 hit_t2 ? {24'h00_0000, cnt[1]} :
                 hit_t3 ? {24'h00_0000, cnt[2]} :
                 hit_rl ? {r3h_q, r3l_q, r2_q, r1_q} :
                 hit_fl ? {29'h0000_0000, flag_q} :
                 hit_wd ? {{(29 - WDT_W){1'b0}}, wdt_q, watchdog_first_stage_flag_q, wef_q,
                           bkup_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (rd) prdata_q <= rdata;
    end
  end

  // Control and reload registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ptw_pkg::CTRL_RST;
      ps_reload_q <= ptw_pkg::RELOAD_RST;
      {r3h_q, r3l_q, r2_q, r1_q} <= 32'h0000_0000;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= pwdata[ptw_pkg::CTRL_W-1:0];
    end else if (wr && hit_ps) begin
      ps_reload_q <= pwdata[15:8];
    end else if (wr && hit_rl) begin
      {r3h_q, r3l_q, r2_q, r1_q} <= pwdata;
    end else if (wr && hit_t3) begin
      r3l_q <= pwdata[15:8];
    end
  end

  // Divider, prescaler, edge register, flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      ps_q <= ptw_pkg::CNT_RST;
      ext_q <= 1'b0;
      flag_q <= 3'h0;
    end else begin
      div_q <= (div_q == $bits(div_q)'(PS_DIV - 1)) ? '0 : div_q + 1'b1;
      ext_q <= external_count_input;
      if (wr && hit_ps) ps_q <= pwdata[7:0];
      else if (ctrl_q[ptw_pkg::CTRL_PS_RUN] && sys_tick)
        ps_q <= (ps_q == '0) ? ps_reload_q : ps_q - 1'b1;
      // Set wins over write-one-to-clear
      flag_q <= (flag_q & ~(wr && hit_fl ? pwdata[2:0] : 3'h0)) | uf;
    end
  end

  // PWM output, forced high by the port C latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_hi_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      if (!ctrl_q[ptw_pkg::CTRL_PWM_EN]) pwm_hi_q <= 1'b0;
      // A stopped timer 3 raises no underflow, so no toggle
      else if (uf[2]) pwm_hi_q <= !pwm_hi_q;
      pwm_q <= (pwm_hi_q && ctrl_q[ptw_pkg::CTRL_PWM_EN]) ||
               ctrl_q[ptw_pkg::CTRL_PORTC];
    end
  end

  // Watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wef_q <= 1'b1;
      watchdog_first_stage_flag_q <= 1'b0;
      dis_pend_q <= 1'b0;
      wdt_q <= '1;
      wdrst_q <= 1'b0;
      bkup_q <= 1'b0;
    end else begin
      wdrst_q <= 1'b0;
      if (wr && hit_wd) begin
        dis_pend_q <= pwdata[ptw_pkg::WD_DISABLE];
        if (pwdata[ptw_pkg::WD_RESTART]) begin
          watchdog_first_stage_flag_q <= 1'b0;
          if (dis_pend_q) wef_q <= 1'b0;
        end
      end
      if (bkup_req) begin
        bkup_q <= 1'b1;
        watchdog_first_stage_flag_q <= 1'b0;
        wdt_q <= '1;
      end else if (wef_q && !bkup_q && sys_tick) begin
        wdt_q <= wdt_q - 1'b1;
        if (wdt_q == '0) begin
          if (watchdog_first_stage_flag_q) wdrst_q <= 1'b1;
          watchdog_first_stage_flag_q <= 1'b1;
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwm_output_pin = pwm_q;
  assign watchdog_reset = wdrst_q;
  assign backup_active = bkup_q;
endmodule // ptw_timer_unit

// File: test/ptw_cpu_model.sv
// CPU-side model: issues timer transfers as an APB master
`timescale 1ns/1ps
module ptw_cpu_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Setup, then access until pready; write data flips once released
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic ok);
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge pclk);
      ok = pready === 1'b1;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // ptw_cpu_model

// File: test/ptw_timer_unit_checker.sv
// Checker: APB handshake, pin and watchdog properties of the timer unit
`timescale 1ns/1ps
module ptw_timer_unit_checker #(parameter int PS_DIV = 4,
  parameter int WDT_W = 16) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic pwm_output_pin,
  input wire logic watchdog_reset,
  input wire logic backup_active
);
  logic wr, pc_q, ext_q;
  assign wr = psel && penable && pready && pwrite;
  // Shadow of the port C latch and clock source bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 1'b1;
      ext_q <= 1'b0;
    end else if (wr && paddr == ptw_pkg::OFF_CTRL) begin
      pc_q <= pwdata[ptw_pkg::CTRL_PORTC];
      ext_q <= pwdata[ptw_pkg::CTRL_EXT_CLK];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_first; psel && penable && !pready; endsequence
  sequence s_pof; wr && paddr == ptw_pkg::OFF_WDOG &&
    pwdata[ptw_pkg::WD_POWEROFF] && ext_q && !backup_active; endsequence
  property p_wait; s_first |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_unmap; psel && penable && pready && paddr > 8'h1C
    |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  property p_map; psel && penable && pready && paddr <= 8'h1C &&
    paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  property p_wd; watchdog_reset |=> !watchdog_reset; endproperty
  property p_bk; backup_active |=> backup_active; endproperty
  property p_pof; s_pof |=> !backup_active [*2]; endproperty
  property p_pc; pc_q && $past(pc_q) && $past(presetn, 2)
    |-> pwm_output_pin; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  a_one: assert property (p_one) else $error("pready too long");
  a_err: assert property (p_err) else $error("error without pready");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_map: assert property (p_map) else $error("mapped access refused");
  a_wd: assert property (p_wd) else $error("watchdog pulse too long");
  a_bk: assert property (p_bk) else $error("backup state dropped");
  a_pof: assert property (p_pof) else $error("backup on ext clock");
  a_pc: assert property (p_pc) else $error("pin low with latch set");
endmodule // ptw_timer_unit_checker

bind ptw_timer_unit ptw_timer_unit_checker #(.PS_DIV(PS_DIV),
  .WDT_W(WDT_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_output_pin(pwm_output_pin), .watchdog_reset(watchdog_reset),
  .backup_active(backup_active));

// File: test/testbench.sv
// Testbench: random and corner scenarios for the timer unit
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, ext, psel, penable, pwrite, pready, pslverr;
  logic pwm, wdr, bk, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, lf;
  int n_fail, cmp_count, n, s, k;
  localparam int PS_DIV = 4;
  ptw_timer_unit #(.PS_DIV(PS_DIV), .WDT_W(4)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(ext), .pwm_output_pin(pwm),
    .watchdog_reset(wdr), .backup_active(bk));
  ptw_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    logic ok;
    cpu.xfer(w, a, d, q, err, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      test_done;
    end
  endtask
  task automatic rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic lvl(input logic v);
    ext <= v;
    repeat (6) @(posedge pclk);
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] ctl(input logic run, input logic fall);
    return 32'(run) << ptw_pkg::CTRL_T1_RUN | 32'(1'b1) <<
      ptw_pkg::CTRL_T1_EXT | 32'(fall) << ptw_pkg::CTRL_T1_FALL;
  endfunction
  initial begin
    n_fail = 0;
    cmp_count = 0;
    ext = 1'b0;
    presetn = 1'b0;
    lf = 32'h0000_0049;
    rst;
    for (n = 0; n < 20000 && wdr !== 1'b1; n++)
      @(negedge pclk);
    chk(32'(n < 20000), 1);
    rst;
    bus(0, ptw_pkg::OFF_CTRL, 0);
    chk(q, 32'(ptw_pkg::CTRL_RST));
    bus(0, ptw_pkg::OFF_WDOG, 0);
    chk(32'(q[1]), 1);
    bus(1, ptw_pkg::OFF_WDOG, 1);
    bus(1, ptw_pkg::OFF_WDOG, 2);
    bus(0, ptw_pkg::OFF_WDOG, 0);
    chk(32'(q[1]), 0);
    bus(0, 8'h40, 0);
    chk(q, 0);
    chk(32'(err), 1);
    for (int f = 0; f < 2; f++) begin
      lf = nxt(lf);
      s = 20 + int'(lf[5:0]);
      k = 2 + int'(lf[9:8]);
      bus(1, ptw_pkg::OFF_RELOAD, lf);
      bus(0, ptw_pkg::OFF_RELOAD, 0);
      chk(q, lf);
      bus(1, ptw_pkg::OFF_T1, 32'(s));
      bus(1, ptw_pkg::OFF_CTRL, ctl(1, f[0]));
      lvl(1);
      bus(1, ptw_pkg::OFF_CTRL, ctl(0, f[0]));
      bus(0, ptw_pkg::OFF_T1, 0);
      chk(q, 32'(s - 1 + f));
      bus(1, ptw_pkg::OFF_CTRL, ctl(1, f[0]));
      lvl(0);
      repeat (k - 1) begin
        lvl(1);
        lvl(0);
      end
      bus(1, ptw_pkg::OFF_CTRL, ctl(0, f[0]));
      bus(0, ptw_pkg::OFF_T1, 0);
      chk(q, 32'(s - k));
      bus(1, ptw_pkg::OFF_CTRL, ctl(1, f[0]));
      q = 32'h0000_0000;
      for (n = 0; n < 300 && q[0] !== 1'b1; n++) begin
        lvl(1);
        lvl(0);
        bus(0, ptw_pkg::OFF_FLAGS, 0);
      end
      chk(32'(k + n == s || k + n == s + 1), 1);
      bus(1, ptw_pkg::OFF_CTRL, ctl(0, f[0]));
      bus(0, ptw_pkg::OFF_T1, 0);
      chk(q, lf & 32'h0000_00FF);
      bus(1, ptw_pkg::OFF_FLAGS, 1);
      bus(0, ptw_pkg::OFF_FLAGS, 0);
      chk(q & 32'h0000_0007, 0);
    end
    // Timer 3 PWM from the prescaler: high H+1 ticks, low L+1 ticks
    lf = nxt(lf);
    k = 1 + int'(lf[1:0]);
    s = 1 + int'(lf[3:2]);
    bus(1, ptw_pkg::OFF_PRESC, 32'h0000_0105);
    bus(0, ptw_pkg::OFF_PRESC, 0);
    chk(q, 32'h0000_0105);
    bus(1, ptw_pkg::OFF_RELOAD, 32'(k) << 24);
    bus(1, ptw_pkg::OFF_T3, 32'(s) << 8);
    bus(1, ptw_pkg::OFF_CTRL, 32'h0000_0109);
    for (n = 0; n < 400 && pwm !== 1'b1; n++)
      @(negedge pclk);
    for (n = 0; n < 400 && pwm === 1'b1; n++)
      @(negedge pclk);
    chk(32'(n), 32'((k + 1) * 2 * PS_DIV));
    for (n = 0; n < 400 && pwm !== 1'b1; n++)
      @(negedge pclk);
    chk(32'(n), 32'((s + 1) * 2 * PS_DIV));
    bus(1, ptw_pkg::OFF_CTRL, 0);
    repeat (2) @(negedge pclk);
    chk(32'(pwm), 0);
    // Watchdog: refused and accepted back-up entry, then restart first
    rst;
    q = 32'h0000_0000;
    for (n = 0; n < 100 && q[2] !== 1'b1; n++)
      bus(0, ptw_pkg::OFF_WDOG, 0);
    bus(1, ptw_pkg::OFF_CTRL, 32'h0000_0400);
    bus(1, ptw_pkg::OFF_WDOG, 4);
    bus(0, ptw_pkg::OFF_WDOG, 0);
    chk(q & 32'h0000_0005, 32'h0000_0004);
    bus(1, ptw_pkg::OFF_CTRL, 0);
    bus(1, ptw_pkg::OFF_WDOG, 4);
    bus(0, ptw_pkg::OFF_WDOG, 0);
    chk(q & 32'h0000_007F, 32'h0000_007B);
    rst;
    bus(1, ptw_pkg::OFF_WDOG, 2);
    bus(1, ptw_pkg::OFF_WDOG, 4);
    bus(0, ptw_pkg::OFF_WDOG, 0);
    chk(q & 32'h0000_0007, 32'h0000_0003);
    test_done;
  end
endmodule // testbench
